// [core/trm_monitor.v]
`timescale 1ns/1ns
`include "trm_defines.vh"
// Functional notes
// - strobes retrigger gap timer while enabled
// - sixty microseconds quiet gives gap event
// - four gaps raise record mark line
// - eight gaps raise file mark line
// - mark counter clears by bit count four or disable
// - active gap detector enables bit counting
// - bit count four clears mark counter
// - bit count eight raises char ready
// - gap timeout zeroes bit counter
// - count eight retriggers file finder timer
// - finder expiry reports file gap found
// - finder enable low suppresses gap reports
// - char end, mark rises and file gap pulse processor event line; plain gaps do not
// - shift register assembles eight-bit characters
module trm_monitor #(
    parameter [31:0] GAP_CYCLES = `TRM_GAP_CYCLES,
    parameter [31:0] FIND_CYCLES = `TRM_FIND_CYCLES,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire gap_find_enable,
    input wire finder_enable_bit,
    input wire read_bit_strobe,
    input wire read_data,
    output wire char_ready,
    output wire record_mark_seen,
    output wire file_mark_seen,
    output reg file_gap_found,
    output reg no_flux_gap,
    output reg port_event,
    output wire char_overrun,
    output wire char_valid,
    input wire char_take,
    output wire [`TRM_CHAR_W-1:0] char_data
);
    // =================================================
    // state
    // =================================================
    reg gap_act_q; // gap detector output, high in a char
    reg [`TRM_TMR_W-1:0] gap_tmr_q; // gap timer
    reg [`TRM_CNT_W-1:0] bit_cnt_q; // bit counter
    reg [`TRM_CNT_W-1:0] mark_cnt_q; // gap (mark) counter
    reg find_act_q; // file finder running
    reg [`TRM_TMR_W-1:0] find_tmr_q; // file finder timer
    reg [`TRM_CHAR_W-1:0] shift_q; // serial to parallel
    reg pend_q; // assembled char waiting for buffer
    reg [`TRM_CHAR_W-1:0] pend_data_q; // waiting char
    reg ovr_q; // char lost while buffer stalled
    reg q8_d1_q; // delayed count-eight tap
    reg rm_d1_q; // delayed record mark
    reg fm_d1_q; // delayed file mark
    wire gap_timeout; // gap timer expires this cycle
    wire find_expire; // finder timer expires this cycle
    wire bit_q8; // bit counter count-eight tap
    wire q8_rise; // count eight just reached
    wire buf_in_ready; // buffer can take a word
    wire [`TRM_CHAR_W-1:0] shift_next; // shift with new bit

    assign gap_timeout = gap_act_q && (gap_tmr_q == 32'h0000_0000);
    assign find_expire = find_act_q && (find_tmr_q == 32'h0000_0000);
    assign bit_q8 = bit_cnt_q[`TRM_BIT_Q8];
    assign q8_rise = bit_q8 && !q8_d1_q;
    assign shift_next = {shift_q[`TRM_CHAR_W-2:0], read_data};
    assign char_ready = bit_q8;
    assign record_mark_seen = mark_cnt_q[`TRM_MARK_Q4];
    assign file_mark_seen = mark_cnt_q[`TRM_MARK_Q8];
    assign char_overrun = ovr_q;

    // =================================================
    // gap detector
    // =================================================
    // retriggerable timer, reloads on every strobe while gap_find_enable is high
    // clk_en low holds the count, so a freeze makes no gap
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_act_q <= 1'b0;
            gap_tmr_q <= 32'h0000_0000;
            no_flux_gap <= 1'b0;
        end else if (clk_en) begin
            no_flux_gap <= 1'b0;
            if (gap_find_enable && read_bit_strobe) begin
                // start or restart the timeout
                gap_act_q <= 1'b1;
                gap_tmr_q <= GAP_CYCLES - 32'h0000_0001;
            end else if (gap_timeout) begin
                // falling edge: one gap found
                gap_act_q <= 1'b0;
                no_flux_gap <= 1'b1;
            end else if (gap_act_q) begin
                gap_tmr_q <= gap_tmr_q - 32'h0000_0001;
            end
        end
    end

    // =================================================
    // bit counter and shift register
    // =================================================
    // wraps at sixteen during fast skips, so the
    // count-eight tap keeps rising for the file finder
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= `TRM_CNT_RST;
            shift_q <= 8'h00;
            q8_d1_q <= 1'b0;
        end else if (clk_en) begin
            q8_d1_q <= bit_q8;
            if (gap_timeout) begin
                // restart counting at next char
                bit_cnt_q <= `TRM_CNT_RST;
            end else if (read_bit_strobe &&
                (gap_act_q || gap_find_enable)) begin
                // counts while detector is triggered or gap finding is enabled
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (read_bit_strobe) begin
                shift_q <= shift_next;
            end
        end
    end

    // =================================================
    // record and file mark counter
    // =================================================
    // clear wins over a gap in the same cycle
    // the gap closing a char still counts once; the
    // next char's count-four clear removes it again
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mark_cnt_q <= `TRM_CNT_RST;
        end else if (clk_en) begin
            if (!gap_find_enable || bit_cnt_q[`TRM_BIT_Q4]) begin
                mark_cnt_q <= `TRM_CNT_RST;
            end else if (gap_timeout && !mark_cnt_q[`TRM_MARK_Q8]) begin
                mark_cnt_q <= mark_cnt_q + 4'h1;
            end
        end
    end

    // =================================================
    // file finder
    // =================================================
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            find_act_q <= 1'b0;
            find_tmr_q <= 32'h0000_0000;
            file_gap_found <= 1'b0;
        end else if (clk_en) begin
            file_gap_found <= 1'b0;
            if (!finder_enable_bit) begin
                // disabled: idle, no reports
                find_act_q <= 1'b0;
            end else if (q8_rise) begin
                find_act_q <= 1'b1;
                find_tmr_q <= FIND_CYCLES - 32'h0000_0001;
            end else if (find_expire) begin
                find_act_q <= 1'b0;
                file_gap_found <= 1'b1;
            end else if (find_act_q) begin
                find_tmr_q <= find_tmr_q - 32'h0000_0001;
            end
        end
    end

    // =================================================
    // processor event line
    // =================================================
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_event <= 1'b0;
            rm_d1_q <= 1'b0;
            fm_d1_q <= 1'b0;
        end else if (clk_en) begin
            rm_d1_q <= record_mark_seen;
            fm_d1_q <= file_mark_seen;
            // char end, marks or inter-file gap
            port_event <= q8_rise || (record_mark_seen && !rm_d1_q) ||
                (file_mark_seen && !fm_d1_q) || file_gap_found;
        end
    end

    // =================================================
    // char capture toward the buffer
    // =================================================
    // holds one char while the buffer is full
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
            pend_data_q <= 8'h00;
            ovr_q <= 1'b0;
        end else if (clk_en) begin
            if (q8_rise) begin
                pend_data_q <= shift_q;
                pend_q <= 1'b1;
                ovr_q <= pend_q && !buf_in_ready;
            end else if (pend_q && buf_in_ready) begin
                pend_q <= 1'b0;
            end
        end
    end

    trm_buf2 #(
        .WIDTH(`TRM_CHAR_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(pend_q),
        .in_ready(buf_in_ready),
        .in_data(pend_data_q),
        .out_valid(char_valid),
        .out_ready(char_take),
        .out_data(char_data)
    );
endmodule

// [shared/trm_defines.vh]
`ifndef TRM_DEFINES_VH
`define TRM_DEFINES_VH
// =====================================================
// clock and timing
// =====================================================
// clock period in ns (100 MHz)
`define TRM_CLK_NS 10
// gap timeout in ns (no strobe for this long marks a gap)
`define TRM_GAP_NS 60000
// file finder period in ns (31.5 ms)
`define TRM_FIND_NS 31500000
// derived cycle counts, rounded down by integer division
`define TRM_GAP_CYCLES (`TRM_GAP_NS / `TRM_CLK_NS)
`define TRM_FIND_CYCLES (`TRM_FIND_NS / `TRM_CLK_NS)
// =====================================================
// field positions
// =====================================================
// bit counter: count-four and count-eight taps
`define TRM_BIT_Q4 2
`define TRM_BIT_Q8 3
// mark counter: record mark and file mark taps
`define TRM_MARK_Q4 2
`define TRM_MARK_Q8 3
// =====================================================
// widths and reset values
// =====================================================
`define TRM_CNT_W 4
`define TRM_CHAR_W 8
`define TRM_CNT_RST 4'h0
`define TRM_TMR_W 32
`endif

// [core/trm_buf2.v]
`timescale 1ns/1ns
// =====================================================
// small fifo with valid/ready on both sides
// =====================================================
module trm_buf2 #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage
    reg [AW-1:0] wr_ptr_q; // write pointer
    reg [AW-1:0] rd_ptr_q; // read pointer
    reg [AW:0] cnt_q; // words held
    reg out_valid_q; // output register holds a word
    wire push; // word taken in
    wire pop; // storage word moved to output register
    wire take; // output register drained

    // honest full and empty
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    assign take = out_valid_q && out_ready;
    assign pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || take);
    assign out_valid = out_valid_q;

    // storage write
    always @(posedge core_clk) begin
        if (clk_en && push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers, count and registered read data
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr_q + 1'b1;
                out_data <= mem_q[rd_ptr_q];
                out_valid_q <= 1'b1;
            end else if (take) begin
                out_valid_q <= 1'b0;
            end
            // count changes only when push and pop differ
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// [tb/trm_chk_monitor.sv]
`timescale 1ns/1ns
// ===========================================
// timing and ordering checks at the ports
module trm_chk #(
    parameter [31:0] GAP_CYCLES = 20
) (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire gap_find_enable,
    input wire finder_enable_bit,
    input wire read_bit_strobe,
    input wire char_take,
    input wire char_ready,
    input wire record_mark_seen,
    input wire file_mark_seen,
    input wire file_gap_found,
    input wire no_flux_gap,
    input wire port_event,
    input wire char_valid,
    input wire [7:0] char_data
);
    reg [31:0] quiet_q; // cycles since last armed strobe
    reg armed_q; // gap timer running
    // follow the gap timer from the strobes
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quiet_q <= 32'h0;
            armed_q <= 1'b0;
        end else if (!clk_en) begin
            // frozen: the design's timer holds as well
            quiet_q <= quiet_q;
        end else if (read_bit_strobe && gap_find_enable) begin
            quiet_q <= 32'h0;
            armed_q <= 1'b1;
        end else begin
            quiet_q <= quiet_q + 32'h1;
            if (no_flux_gap || !gap_find_enable)
                armed_q <= 1'b0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_gap_time;
        no_flux_gap |-> $past(armed_q) && $past(quiet_q) == GAP_CYCLES - 1;
    endproperty
    a_gap_time: assert property (p_gap_time)
        else $error("gap pulse at wrong time");
    property p_gap_due;
        armed_q && quiet_q == GAP_CYCLES |-> no_flux_gap;
    endproperty
    a_gap_due: assert property (p_gap_due)
        else $error("gap pulse missing");
    property p_mark_clear;
        !gap_find_enable |=> !record_mark_seen && !file_mark_seen;
    endproperty
    a_mark_clear: assert property (p_mark_clear)
        else $error("marks not cleared");
    property p_mark_excl;
        file_mark_seen |-> !record_mark_seen;
    endproperty
    a_mark_excl: assert property (p_mark_excl)
        else $error("both marks high");
    property p_ready_cause;
        $rose(char_ready) |-> $past(read_bit_strobe);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("char ready without strobe");
    property p_ready_event;
        $rose(char_ready) |=> port_event;
    endproperty
    a_ready_event: assert property (p_ready_event)
        else $error("no event after char end");
    property p_find_en;
        file_gap_found |-> $past(finder_enable_bit);
    endproperty
    a_find_en: assert property (p_find_en)
        else $error("file gap while disabled");
    property p_hold;
        char_valid && !char_take |=> char_valid && $stable(char_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("char lost while stalled");
    c_rec: cover property ($rose(record_mark_seen));
    c_file: cover property ($rose(file_mark_seen));
    c_find: cover property (file_gap_found);
endmodule
bind trm_monitor trm_chk #(.GAP_CYCLES(GAP_CYCLES)) u_chk (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .gap_find_enable(gap_find_enable),
    .finder_enable_bit(finder_enable_bit), .char_take(char_take),
    .read_bit_strobe(read_bit_strobe), .char_ready(char_ready),
    .record_mark_seen(record_mark_seen), .file_mark_seen(file_mark_seen),
    .file_gap_found(file_gap_found), .no_flux_gap(no_flux_gap),
    .port_event(port_event), .char_valid(char_valid), .char_data(char_data)
);

// [tb/trm_cpu_model.sv]
`timescale 1ns/1ns
// ===========================================
// processor side: takes chars, stalls at random
module trm_cpu_model (
    input wire core_clk,
    input wire stall,
    input wire char_valid,
    input wire [7:0] char_data,
    output reg char_take,
    output reg got,
    output reg [7:0] got_data
);
    initial char_take = 1'b0;
    // waits on words only, never on tape markers
    always @(negedge core_clk)
        char_take <= !stall && ($urandom % 3 != 0);
    // report each word taken
    always @(posedge core_clk) begin
        got <= char_valid && char_take;
        got_data <= char_data;
    end
endmodule

// [tb/trm_monitor_tb_top.sv]
`timescale 1ns/1ns
// ===========================================
// bench: stimulus, expected words, verdict
module trm_monitor_tb_top;
    localparam GAP = 20;
    localparam FIND = 200;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg gfe = 1'b0; // gap finding enable
    reg fen = 1'b0; // file finder enable
    reg stb = 1'b0;
    reg rd = 1'b0;
    reg stall = 1'b1;
    reg check_on = 1'b1;
    reg ce = 1'b1; // clock enable toward the design
    reg frz_on = 1'b0; // freeze the next char midway
    wire rdy, rec, fil, fnd, nfg, pev, ovr, cv, take, got;
    wire [7:0] cd, gd;
    integer mismatches = 0, n_checks = 0, n_find = 0, k, i;
    integer n_gap = 0, n_ev = 0; // gap and event pulses seen
    reg [7:0] exp_q[$];
    always #5 core_clk = ~core_clk;
    trm_monitor #(.GAP_CYCLES(GAP), .FIND_CYCLES(FIND)) dut (
        .core_clk(core_clk), .rst(rst), .clk_en(ce),
        .gap_find_enable(gfe), .finder_enable_bit(fen),
        .read_bit_strobe(stb), .read_data(rd), .char_ready(rdy),
        .record_mark_seen(rec), .file_mark_seen(fil),
        .file_gap_found(fnd), .no_flux_gap(nfg), .port_event(pev),
        .char_overrun(ovr), .char_valid(cv), .char_take(take),
        .char_data(cd));
    trm_cpu_model u_cpu (.core_clk(core_clk), .stall(stall),
        .char_valid(cv), .char_data(cd), .char_take(take), .got(got),
        .got_data(gd));
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task strobe(input d, input integer idle);
        begin
            @(negedge core_clk) stb = 1'b1;
            rd = d;
            @(negedge core_clk) stb = 1'b0;
            repeat (idle) @(negedge core_clk);
        end
    endtask
    task send_char(input [7:0] v, input push);
        begin
            if (push)
                exp_q.push_back(v);
            n_gap = 0;
            n_ev = 0;
            for (i = 7; i > 0; i = i - 1) begin
                strobe(v[i], $urandom % 3);
                if (frz_on && i == 4) begin
                    // enable low for longer than a gap time
                    stall = 1'b1;
                    @(negedge core_clk) ce = 1'b0;
                    repeat (GAP + 10) @(negedge core_clk);
                    ce = 1'b1;
                    stall = 1'b0;
                end
            end
            strobe(v[0], 1);
            chk(rdy, 1);
            repeat (GAP + 4) @(negedge core_clk);
            chk(rdy, 0);
            chk(n_gap, 1);
            chk(n_ev, 1);
        end
    endtask
    // compare each word taken while check_on is set, count finder reports
    always @(negedge core_clk) begin
        if (got && check_on)
            chk(gd, exp_q.pop_front());
        if (fnd)
            n_find = n_find + 1;
        if (nfg)
            n_gap = n_gap + 1;
        if (pev)
            n_ev = n_ev + 1;
    end
    initial begin
        void'($urandom(32'h0A6EA60C));
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        for (k = 1; k <= 9; k = k + 1) begin
            gfe = 1'b0;
            n_gap = 0;
            n_ev = 0;
            @(negedge core_clk) gfe = 1'b1;
            repeat (k) strobe($urandom, GAP + 4);
            chk(rec, k >= 4 && k < 8);
            chk(fil, k >= 8);
            chk(n_gap, k);
            chk(n_ev, (k >= 4) + (k >= 8));
        end
        stall = 1'b0;
        send_char($urandom, 1);
        chk(fil, 0);
        frz_on = 1'b1;
        send_char($urandom, 1);
        frz_on = 1'b0;
        for (k = 0; k < 6; k = k + 1)
            send_char($urandom, 1);
        stall = 1'b1;
        repeat (3) send_char($urandom, 1);
        chk(cv, 1);
        chk(ovr, 0);
        stall = 1'b0;
        repeat (30) @(negedge core_clk);
        chk(exp_q.size(), 0);
        stall = 1'b1;
        check_on = 1'b0;
        repeat (6) send_char($urandom, 0);
        chk(ovr, 1);
        stall = 1'b0;
        repeat (40) @(negedge core_clk);
        fen = 1'b1;
        repeat (400) strobe($urandom, 0);
        chk(n_find, 0);
        repeat (FIND + 20) @(negedge core_clk);
        chk(n_find, 1);
        fen = 1'b0;
        repeat (400) strobe($urandom, 0);
        repeat (FIND + 20) @(negedge core_clk);
        chk(n_find, 1);
        repeat (40) @(negedge core_clk);
        check_on = 1'b1;
        send_char($urandom, 1);
        chk(ovr, 0);
        repeat (20) @(negedge core_clk);
        chk(exp_q.size(), 0);
        rst = 1'b1;
        @(negedge core_clk);
        chk({rdy, rec, fil, fnd, nfg, pev, ovr, cv}, 0);
        rst = 1'b0;
        send_char($urandom, 1);
        repeat (30) @(negedge core_clk);
        chk(exp_q.size(), 0);
        tally_and_finish;
    end
    // hang guard
    initial begin
        #300000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule
